/* File: src/crv_reset_values.sv */
// cpu control/status register bank with hardware and software reset values
//
// The implementer's own choices: the strobed register port and the register addresses.
`include "crv_params.svh"
module crv_reset_values (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             clk_en,
   input  wire logic             sw_reset,
   input  wire crv_pkg::crv_addr_t reg_addr,
   input  wire crv_pkg::crv_word_t reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output crv_pkg::crv_word_t    reg_rdata,
   output logic                  external_flag_pin,
   output logic                  global_irq_mask,
   output logic                  legacy_compat_mode,
   output logic                  vec_fetch_req,
   output crv_pkg::crv_paddr_t   vec_fetch_addr
);
   import crv_pkg::*;

   crv_regs_s cur_ff;
   crv_regs_s nxt_regs;
   crv_word_t rd_val;

   // read mux; unmapped indices read zero
   always_comb begin
      rd_val = '0;
      if (reg_addr == `CRV_IDX_VPP) begin
         rd_val = cur_ff.vpp;
      end else if (reg_addr == `CRV_IDX_HVPP) begin
         rd_val = cur_ff.hvpp;
      end else if (reg_addr == `CRV_IDX_CSA_A) begin
         rd_val = cur_ff.csa_a;
      end else if (reg_addr == `CRV_IDX_CSA_B) begin
         rd_val = cur_ff.csa_b;
      end else if (reg_addr == `CRV_IDX_CSA_C) begin
         rd_val = cur_ff.csa_c;
      end else if (reg_addr == `CRV_IDX_CSA_D) begin
         rd_val = cur_ff.csa_d;
      end else if (reg_addr == `CRV_IDX_CIE_LO) begin
         rd_val = cur_ff.cie_lo;
      end else if (reg_addr == `CRV_IDX_CIE_HI) begin
         rd_val = cur_ff.cie_hi;
      end else if (reg_addr == `CRV_IDX_IE_LO) begin
         rd_val = cur_ff.ie_lo;
      end else if (reg_addr == `CRV_IDX_IE_HI) begin
         rd_val = cur_ff.ie_hi;
      end else if (reg_addr == `CRV_IDX_IP_LO) begin
         rd_val = cur_ff.ip_lo;
      end else if (reg_addr == `CRV_IDX_IP_HI) begin
         rd_val = cur_ff.ip_hi;
      end else if (reg_addr == `CRV_IDX_RPT) begin
         rd_val = cur_ff.rpt;
      end else if (reg_addr == `CRV_IDX_ST0) begin
         rd_val = cur_ff.st0;
      end else if (reg_addr == `CRV_IDX_ST1) begin
         rd_val = cur_ff.st1;
      end else if (reg_addr == `CRV_IDX_ST2) begin
         rd_val = cur_ff.st2;
      end else if (reg_addr == `CRV_IDX_T2) begin
         rd_val = cur_ff.t2;
      end
   end

   // next state: register writes, then software reset overrides them
   always_comb begin
      nxt_regs = cur_ff;
      nxt_regs.vec_req = 1'b0;
      if (reg_rd) begin
         nxt_regs.rdata = rd_val;
      end
      if (reg_wr) begin
         if (reg_addr == `CRV_IDX_VPP) begin
            nxt_regs.vpp = reg_wdata;
         end else if (reg_addr == `CRV_IDX_HVPP) begin
            nxt_regs.hvpp = reg_wdata;
         end else if (reg_addr == `CRV_IDX_CSA_A) begin
            nxt_regs.csa_a = reg_wdata;
         end else if (reg_addr == `CRV_IDX_CSA_B) begin
            nxt_regs.csa_b = reg_wdata;
         end else if (reg_addr == `CRV_IDX_CSA_C) begin
            nxt_regs.csa_c = reg_wdata;
         end else if (reg_addr == `CRV_IDX_CSA_D) begin
            nxt_regs.csa_d = reg_wdata;
         end else if (reg_addr == `CRV_IDX_CIE_LO) begin
            nxt_regs.cie_lo = reg_wdata;
         end else if (reg_addr == `CRV_IDX_CIE_HI) begin
            nxt_regs.cie_hi = reg_wdata;
         end else if (reg_addr == `CRV_IDX_IE_LO) begin
            nxt_regs.ie_lo = reg_wdata;
         end else if (reg_addr == `CRV_IDX_IE_HI) begin
            nxt_regs.ie_hi = reg_wdata;
         end else if (reg_addr == `CRV_IDX_IP_LO) begin
            nxt_regs.ip_lo = reg_wdata;
         end else if (reg_addr == `CRV_IDX_IP_HI) begin
            nxt_regs.ip_hi = reg_wdata;
         end else if (reg_addr == `CRV_IDX_RPT) begin
            nxt_regs.rpt = reg_wdata;
         end else if (reg_addr == `CRV_IDX_ST0) begin
            nxt_regs.st0 = reg_wdata;
         end else if (reg_addr == `CRV_IDX_ST1) begin
            nxt_regs.st1 = reg_wdata;
         end else if (reg_addr == `CRV_IDX_ST2) begin
            nxt_regs.st2 = reg_wdata;
         end else if (reg_addr == `CRV_IDX_T2) begin
            nxt_regs.t2 = reg_wdata;
         end
      end
      // the fetch request goes out one cycle after either reset
      case (cur_ff.state)
         CRV_VEC_FETCH: begin
            nxt_regs.vec_req = 1'b1;
            nxt_regs.state   = CRV_RUN;
         end
         default: begin
            nxt_regs.state = CRV_RUN;
         end
      endcase
      if (sw_reset) begin
         nxt_regs.ip_lo = '0;
         nxt_regs.ip_hi = '0;
         nxt_regs.st0 = `CRV_ST0_RST;
         nxt_regs.st0 = `CRV_ST0_RST;
         nxt_regs.st1 = `CRV_ST1_RST;
         nxt_regs.t2  = '0;
         nxt_regs.st2 = cur_ff.st2 & `CRV_ST2_MASK;
         nxt_regs.vpp   = cur_ff.vpp;
         nxt_regs.state = CRV_VEC_FETCH;
      end
   end

   // single state register; hardware reset gives every documented value
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cur_ff          <= '0;
         cur_ff.vpp      <= `CRV_VPP_RST;
         cur_ff.hvpp     <= `CRV_VPP_RST;
         cur_ff.st0      <= `CRV_ST0_RST;
         cur_ff.st1      <= `CRV_ST1_RST;
         cur_ff.state    <= CRV_VEC_FETCH;
      end else if (clk_en) begin
         cur_ff <= nxt_regs;
      end
   end

   // outputs straight from the state register
   assign reg_rdata          = cur_ff.rdata;
   assign external_flag_pin  = cur_ff.st1[`CRV_ST1_XF];
   assign global_irq_mask    = cur_ff.st1[`CRV_ST1_GLOBAL_IRQ_MASK];
   assign legacy_compat_mode = cur_ff.st1[`CRV_ST1_LEGACY];
   assign vec_fetch_req      = cur_ff.vec_req;
   assign vec_fetch_addr     = {cur_ff.vpp, `CRV_VEC_LOW};
endmodule // crv_reset_values

/* File: src/crv_params.svh */
// constants for the cpu reset-value register bank
`ifndef CRV_PARAMS_SVH
`define CRV_PARAMS_SVH
// register indices on the plain register port
`define CRV_IDX_VPP     5'h00
`define CRV_IDX_HVPP    5'h01
`define CRV_IDX_CSA_A   5'h02
`define CRV_IDX_CSA_B   5'h03
`define CRV_IDX_CSA_C   5'h04
`define CRV_IDX_CSA_D   5'h05
`define CRV_IDX_CIE_LO  5'h06
`define CRV_IDX_CIE_HI  5'h07
`define CRV_IDX_IE_LO   5'h08
`define CRV_IDX_IE_HI   5'h09
`define CRV_IDX_IP_LO   5'h0a
`define CRV_IDX_IP_HI   5'h0b
`define CRV_IDX_RPT     5'h0c
`define CRV_IDX_ST0     5'h0d
`define CRV_IDX_ST1     5'h0e
`define CRV_IDX_ST2     5'h0f
`define CRV_IDX_T2      5'h10
// reset values, the software reset mask for status two and the vector low byte
`define CRV_VPP_RST     16'hffff
`define CRV_ST0_RST     16'h3800
`define CRV_ST1_RST     16'h2920
`define CRV_ST2_MASK    16'hff80
`define CRV_VEC_LOW     8'h00
// field positions
`define CRV_ST1_ASM_HI  4
`define CRV_ST1_XF      13
`define CRV_ST1_GLOBAL_IRQ_MASK    11
`define CRV_ST1_LEGACY  5
`endif

/* File: src/crv_pkg.sv */
// types for the cpu reset-value register bank
package crv_pkg;
   typedef logic [15:0] crv_word_t;
   typedef logic [4:0]  crv_addr_t;
   typedef logic [23:0] crv_paddr_t;
   typedef enum logic [1:0] {CRV_RUN, CRV_VEC_FETCH} crv_state_e;
   typedef struct packed {
      crv_state_e state;
      crv_word_t  vpp;
      crv_word_t  hvpp;
      crv_word_t  csa_a;
      crv_word_t  csa_b;
      crv_word_t  csa_c;
      crv_word_t  csa_d;
      crv_word_t  cie_lo;
      crv_word_t  cie_hi;
      crv_word_t  ie_lo;
      crv_word_t  ie_hi;
      crv_word_t  ip_lo;
      crv_word_t  ip_hi;
      crv_word_t  rpt;
      crv_word_t  st0;
      crv_word_t  st1;
      crv_word_t  st2;
      crv_word_t  t2;
      crv_word_t  rdata;
      crv_paddr_t vec_addr;
      logic       vec_req;
   } crv_regs_s;
endpackage

/* File: sim/crv_reset_values_chk.sv */
// assertion checker for the cpu reset-value bank ports
`include "crv_params.svh"
module crv_reset_values_chk (
   input wire logic                mclk,
   input wire logic                rst,
   input wire logic                clk_en,
   input wire logic                sw_reset,
   input wire crv_pkg::crv_addr_t  reg_addr,
   input wire crv_pkg::crv_word_t  reg_wdata,
   input wire logic                reg_wr,
   input wire logic                reg_rd,
   input wire crv_pkg::crv_word_t  reg_rdata,
   input wire logic                external_flag_pin,
   input wire logic                global_irq_mask,
   input wire logic                legacy_compat_mode,
   input wire logic                vec_fetch_req,
   input wire crv_pkg::crv_paddr_t vec_fetch_addr
);
   import crv_pkg::*;
   crv_word_t wdata_ff;
   // delayed write word, so pins can be tied to what was written
   always_ff @(posedge mclk) begin
      wdata_ff <= reg_wdata;
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   a_pins_follow_wr: assert property (reg_wr && clk_en && !sw_reset && reg_addr == `CRV_IDX_ST1 |=>
      {external_flag_pin, global_irq_mask, legacy_compat_mode} == {wdata_ff[13], wdata_ff[11], wdata_ff[5]})
      else $error("status pins differ from written word");
   a_swr_sets_modes: assert property (sw_reset && clk_en |=>
      external_flag_pin && global_irq_mask && legacy_compat_mode)
      else $error("mode pins not set by software reset");
   a_swr_fetch_req: assert property (sw_reset && clk_en |-> ##[1:3] vec_fetch_req)
      else $error("no vector fetch after software reset");
   a_hw_first_fetch: assert property ($past(rst) |-> ##[1:2] vec_fetch_req && vec_fetch_addr == 24'hffff00)
      else $error("no vector fetch from top page after reset");
   a_vec_page_low: assert property (vec_fetch_req |-> vec_fetch_addr[7:0] == 8'h00)
      else $error("vector address not page aligned");
   a_req_one_cycle: assert property (vec_fetch_req |=> !vec_fetch_req)
      else $error("vector fetch request longer than one cycle");
   a_swr_st0_read: assert property (sw_reset && clk_en ##1 reg_rd && clk_en && reg_addr == `CRV_IDX_ST0 |=>
      reg_rdata == 16'h3800)
      else $error("status word zero wrong after software reset");
   a_rdata_holds: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
      else $error("read data changed without a read");
endmodule // crv_reset_values_chk
bind crv_reset_values crv_reset_values_chk u_chk (.mclk, .rst, .clk_en, .sw_reset, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .external_flag_pin, .global_irq_mask, .legacy_compat_mode,
   .vec_fetch_req, .vec_fetch_addr);

/* File: sim/crv_reset_values_tb_top.sv */
// self-checking bench for the cpu reset-value bank
module crv_reset_values_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import crv_pkg::*;
   logic       mclk = 1'h0, rst = 1'h1, clk_en = 1'h1, sw_reset = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
   logic       external_flag_pin, global_irq_mask, legacy_compat_mode, vec_fetch_req;
   crv_addr_t  reg_addr = 5'h00;
   crv_word_t  reg_wdata = 16'h0000, reg_rdata, wrote [17];
   crv_paddr_t vec_fetch_addr;
   int         mismatches = 0, tests_run = 0, cycles = 0;
   crv_reset_values dut (.mclk, .rst, .clk_en, .sw_reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .external_flag_pin, .global_irq_mask, .legacy_compat_mode, .vec_fetch_req, .vec_fetch_addr);
   // 50 ns period
   initial begin
      forever #25 mclk = ~mclk;
   end
   // the whole run needs well under a thousand cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 4000) begin
         mismatches++;
         report_and_stop();
      end
   end
   task automatic cmp_word(string what, crv_word_t exp, crv_word_t got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmp_addr(string what, crv_paddr_t exp, crv_paddr_t got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(crv_addr_t a, crv_word_t d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge mclk);
      reg_wr <= 1'h0;
   endtask
   // data is looked at in the single cycle after the strobe
   task automatic rd(crv_addr_t a, crv_word_t exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge mclk);
      reg_rd <= 1'h0;
      #1 cmp_word($sformatf("reg %h", a), exp, reg_rdata);
   endtask
   function automatic crv_word_t exp_val(int i, logic hw);
      case (i)
         10, 11, 16: return 16'h0000;
         13: return 16'h3800;
         14: return 16'h2920;
         15: return hw ? 16'h0000 : (wrote[i] & 16'hff80);
         0, 1: return hw ? 16'hffff : wrote[i];
         default: return hw ? 16'h0000 : wrote[i];
      endcase
   endfunction
   task automatic hw_reset_scn();
      int n;
      // raise reset on a rising edge, like every other input
      @(posedge mclk);
      rst <= 1'h1;
      repeat (10) @(posedge mclk);
      rst <= 1'h0;
      #1;
      for (n = 0; n < 4 && vec_fetch_req !== 1'h1; n++) #50;
      cmp_addr("fetch address", 24'hffff00, vec_fetch_addr);
      cmp_word("mode pins", 16'h0007, {13'h0000, external_flag_pin, global_irq_mask, legacy_compat_mode});
      for (int i = 0; i < 17; i++) rd(i[4:0], exp_val(i, 1'h1));
      rd(5'h11, 16'h0000);
   endtask
   // distinct words, status one written with its three pin bits low
   task automatic write_all_scn();
      for (int i = 0; i < 17; i++) begin
         wrote[i] = 16'hc4c0 ^ 16'(i);
         wr(i[4:0], wrote[i]);
      end
      wr(5'h11, 16'hffff);
      for (int i = 0; i < 17; i++) rd(i[4:0], wrote[i]);
      rd(5'h11, 16'h0000);
      cmp_word("mode pins", 16'h0000, {13'h0000, external_flag_pin, global_irq_mask, legacy_compat_mode});
   endtask
   task automatic sw_reset_scn();
      @(posedge mclk);
      sw_reset <= 1'h1;
      @(posedge mclk);
      // read status zero right behind the reset strobe, so the back-to-back case is exercised
      sw_reset <= 1'h0;
      reg_addr <= 5'h0d;
      reg_rd <= 1'h1;
      @(posedge mclk);
      reg_rd <= 1'h0;
      #1 cmp_word("reg 0d", 16'h3800, reg_rdata);
      cmp_word("fetch request", 16'h0001, {15'h0000, vec_fetch_req});
      cmp_addr("fetch address", {wrote[0], 8'h00}, vec_fetch_addr);
      for (int i = 0; i < 17; i++) rd(i[4:0], exp_val(i, 1'h0));
      cmp_word("mode pins", 16'h0007, {13'h0000, external_flag_pin, global_irq_mask, legacy_compat_mode});
   endtask
   // a write while the clock enable is low must be lost
   task automatic hold_scn();
      @(posedge mclk);
      clk_en <= 1'h0;
      wr(5'h02, 16'h0000);
      clk_en <= 1'h1;
      rd(5'h02, wrote[2]);
   endtask
   task automatic report_and_stop();
      if (mismatches == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      hw_reset_scn();
      write_all_scn();
      sw_reset_scn();
      hold_scn();
      hw_reset_scn();
      report_and_stop();
   end
endmodule // crv_reset_values_tb_top
